// >>> phy_cfg_pkg.sv
package phy_cfg_pkg;

   // board reset low time, kept by the reset source, not checked here
   localparam int CLK_HZ = 10_000_000;
   localparam int RESET_MIN_US = 160;
   localparam int RESET_MIN_CYC = (RESET_MIN_US * (CLK_HZ / 1_000_000));

   // register indices; byte address is four times the index
   localparam logic [5:0] CTRL_IDX = 6'h00;
   localparam logic [5:0] ADV_IDX = 6'h04;
   localparam logic [5:0] LPAR_IDX = 6'h05;
   localparam logic [5:0] STAT_IDX = 6'h11;

   // basic mode control fields
   localparam int CTRL_SPEED = 13;
   localparam int CTRL_NEG_EN = 12;
   localparam int CTRL_RESTART = 9;
   localparam int CTRL_DUPLEX = 8;
   localparam logic [15:0] CTRL_WMASK = 16'h3300;

   // advertised ability fields
   localparam int ABIL_LSB = 5;
   localparam logic [4:0] SELECTOR = 5'h01;
   localparam logic [15:0] ADV_WMASK = 16'h01E0;
   localparam logic [15:0] ADV_RESET = 16'h0001;

   // status fields
   localparam int STAT_COMPLETE = 0;
   localparam int STAT_SPEED = 1;
   localparam int STAT_DUPLEX = 2;
   localparam int STAT_ANEN = 3;

   // ability vector order: 10 half, 10 full, 100 half, 100 full
   localparam logic [3:0] AB_10HD = 4'h1;
   localparam logic [3:0] AB_10FD = 4'h2;
   localparam logic [3:0] AB_100HD = 4'h4;
   localparam logic [3:0] AB_100FD = 4'h8;

   function automatic logic [3:0] strap_ability(input logic en, input logic hi, input logic lo);
      logic [3:0] a;
      a = 4'h0;
      if (!en) begin
         case ({hi, lo})
            2'b00: a = AB_10HD;
            2'b01: a = AB_10FD;
            2'b10: a = AB_100HD;
            default: a = AB_100FD;
         endcase
      end else begin
         case ({hi, lo})
            2'b00: a = AB_10HD | AB_10FD;
            2'b01: a = AB_100HD | AB_100FD;
            2'b10: a = AB_10HD | AB_100HD;
            default: a = 4'hF;
         endcase
      end
      return a;
   endfunction : strap_ability

endpackage : phy_cfg_pkg

// >>> ability_if.sv
`timescale 1ns/1ps
interface ability_if;
   logic [3:0] common;
   logic found;
   logic speed100;
   logic fullDuplex;
   modport requester (output common, input found, input speed100, input fullDuplex);
   modport resolver (input common, output found, output speed100, output fullDuplex);
endinterface : ability_if

// >>> mode_resolver.sv
`timescale 1ns/1ps
module mode_resolver
   import phy_cfg_pkg::*;
(
   ability_if.resolver abl
);
   always_comb begin
      abl.found = 1'b1;
      abl.speed100 = 1'b0;
      abl.fullDuplex = 1'b0;
      if ((abl.common & AB_100FD) != 4'h0) begin
         abl.speed100 = 1'b1;
         abl.fullDuplex = 1'b1;
      end else if ((abl.common & AB_100HD) != 4'h0) begin
         abl.speed100 = 1'b1;
      end else if ((abl.common & AB_10FD) != 4'h0) begin
         abl.fullDuplex = 1'b1;
      end else if ((abl.common & AB_10HD) == 4'h0) begin
         abl.found = 1'b0;
      end
   end
endmodule : mode_resolver

// >>> phy_strap_config.sv
// How it works
// - reset restores every register default and samples the straps again.
// - strap levels at reset set advertised ability bits 8 to 5.
// - enable strap low: ability straps force one speed and duplex mode.
// - enable strap high: ability straps pick which modes are advertised.
// - a write to basic mode control may change negotiation later.
// - abilities exchanged with partner; best common mode is chosen.
// - negotiation set either by register writes or by straps alone.
// - rank 100 full, 100 half, 10 full, 10 half.
// - negotiation off: speed and duplex bits set mode; ignored when on.
`timescale 1ns/1ps
module phy_strap_config
   import phy_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic negotiationEnableStrap,
   input wire logic abilitySelectStrapHi,
   input wire logic abilitySelectStrapLo,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [3:0] partnerAbility,
   input wire logic partnerValid,
   output logic [15:0] advertisedWord,
   output logic restartPulse,
   output logic negotiationEnabled,
   output logic negotiationComplete,
   output logic speed100,
   output logic fullDuplex
);

   logic [2:0] strapMeta_reg;
   logic [2:0] strapSync_reg;
   logic strapDone_reg, strapDone_next;
   logic [2:0] strapCap_reg, strapCap_next;
   logic [15:0] basicModeControl_reg, basicModeControl_next;
   logic [15:0] advertisedAbility_reg, advertisedAbility_next;
   logic [3:0] lpAbility_reg, lpAbility_next;
   logic ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic restart_reg, restart_next;
   logic complete_reg, complete_next;
   logic speed_reg, speed_next;
   logic duplex_reg, duplex_next;
   logic wrAcc;
   logic [5:0] idx;
   logic aligned;
   logic [15:0] wmask;
   logic [3:0] fromStraps;

   ability_if abl ();
   mode_resolver mode_resolver_i (.abl(abl));

   // pins from the board: two flops, no reset so the levels are valid at release
   always_ff @(posedge clk) begin
      strapMeta_reg <= {negotiationEnableStrap, abilitySelectStrapHi, abilitySelectStrapLo};
      strapSync_reg <= strapMeta_reg;
   end

   assign idx = address[7:2];
   assign aligned = (address[1:0] == 2'b00);
   assign wrAcc = write && ack_reg;
   assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
   assign fromStraps = strap_ability(strapSync_reg[2], strapSync_reg[1], strapSync_reg[0]);
   assign abl.common = advertisedAbility_reg[ABIL_LSB +: 4] & lpAbility_reg;

   always_comb begin
      strapDone_next = 1'b1;
      strapCap_next = strapCap_reg;
      basicModeControl_next = basicModeControl_reg;
      advertisedAbility_next = advertisedAbility_reg;
      lpAbility_next = lpAbility_reg;
      ack_next = (read || write) && !ack_reg;
      rdata_next = rdata_reg;
      restart_next = 1'b0;
      complete_next = complete_reg;
      speed_next = speed_reg;
      duplex_next = duplex_reg;
      if (!strapDone_reg) begin
         // one capture after release; pins are ignored from then on
         strapCap_next = strapSync_reg;
         advertisedAbility_next[ABIL_LSB +: 4] = fromStraps;
         basicModeControl_next[CTRL_NEG_EN] = strapSync_reg[2];
         basicModeControl_next[CTRL_SPEED] = !strapSync_reg[2] && strapSync_reg[1];
         basicModeControl_next[CTRL_DUPLEX] = !strapSync_reg[2] && strapSync_reg[0];
      end else if (wrAcc && aligned) begin
         if (idx == CTRL_IDX) begin
            basicModeControl_next = (basicModeControl_reg & ~(wmask & CTRL_WMASK))
               | (writedata[15:0] & wmask & CTRL_WMASK);
            restart_next = byteenable[1] && writedata[CTRL_RESTART];
            if (byteenable[1] && (writedata[CTRL_NEG_EN] != basicModeControl_reg[CTRL_NEG_EN]))
               restart_next = 1'b1;
         end else if (idx == ADV_IDX) begin
            advertisedAbility_next = (advertisedAbility_reg & ~(wmask & ADV_WMASK))
               | (writedata[15:0] & wmask & ADV_WMASK);
         end
      end
      if (read && !ack_reg) begin
         rdata_next = 32'h0000_0000;
         if (aligned) begin
            case (idx)
               CTRL_IDX: rdata_next[15:0] = basicModeControl_reg;
               ADV_IDX: rdata_next[15:0] = advertisedAbility_reg;
               LPAR_IDX: rdata_next[15:0] = {7'h00, lpAbility_reg, SELECTOR};
               STAT_IDX: begin
                  rdata_next[STAT_COMPLETE] = complete_reg;
                  rdata_next[STAT_SPEED] = speed_reg;
                  rdata_next[STAT_DUPLEX] = duplex_reg;
                  rdata_next[STAT_ANEN] = basicModeControl_reg[CTRL_NEG_EN];
               end
               default: rdata_next = 32'h0000_0000;
            endcase
         end
      end
      // negotiation outcome; a restart clears complete and partner abilities but keeps speed and duplex
      if (!basicModeControl_reg[CTRL_NEG_EN]) begin
         speed_next = basicModeControl_reg[CTRL_SPEED];
         duplex_next = basicModeControl_reg[CTRL_DUPLEX];
         complete_next = 1'b0;
         lpAbility_next = 4'h0;
      end else if (restart_reg) begin
         complete_next = 1'b0;
         lpAbility_next = 4'h0;
      end else if (partnerValid) begin
         lpAbility_next = partnerAbility;
         complete_next = 1'b0;
      end else if (!complete_reg && abl.found && strapDone_reg) begin
         speed_next = abl.speed100;
         duplex_next = abl.fullDuplex;
         complete_next = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         strapDone_reg <= 1'b0;
         strapCap_reg <= 3'h0;
         basicModeControl_reg <= 16'h0000;
         advertisedAbility_reg <= ADV_RESET;
         lpAbility_reg <= 4'h0;
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         restart_reg <= 1'b0;
         complete_reg <= 1'b0;
         speed_reg <= 1'b0;
         duplex_reg <= 1'b0;
      end else begin
         strapDone_reg <= strapDone_next;
         strapCap_reg <= strapCap_next;
         basicModeControl_reg <= basicModeControl_next;
         advertisedAbility_reg <= advertisedAbility_next;
         lpAbility_reg <= lpAbility_next;
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         restart_reg <= restart_next;
         complete_reg <= complete_next;
         speed_reg <= speed_next;
         duplex_reg <= duplex_next;
      end
   end

   // one wait state on every access keeps read data registered
   assign waitrequest = (read || write) && !ack_reg;
   assign readdata = rdata_reg;
   assign advertisedWord = advertisedAbility_reg;
   assign restartPulse = restart_reg;
   assign negotiationEnabled = basicModeControl_reg[CTRL_NEG_EN];
   assign negotiationComplete = complete_reg;
   assign speed100 = speed_reg;
   assign fullDuplex = duplex_reg;

   sequence sReleaseLoad;
      !strapDone_reg ##1 strapDone_reg;
   endsequence

   sequence sCtrlWrite;
      write && aligned && idx == CTRL_IDX && byteenable[1] && waitrequest ##1 !waitrequest;
   endsequence

   a_reset_defaults: assert property (@(posedge clk) !resetn |=>
      !strapDone_reg && advertisedAbility_reg == ADV_RESET && !complete_reg && !ack_reg)
      else $error("registers not at defaults after reset");

   a_strap_ability: assert property (@(posedge clk) disable iff (!resetn) sReleaseLoad |->
      advertisedAbility_reg[ABIL_LSB +: 4] == strap_ability($past(strapSync_reg[2]),
         $past(strapSync_reg[1]), $past(strapSync_reg[0])))
      else $error("advertised ability does not follow straps");

   a_forced_strap: assert property (@(posedge clk) disable iff (!resetn)
      sReleaseLoad ##0 !strapCap_reg[2] |-> !basicModeControl_reg[CTRL_NEG_EN]
      && basicModeControl_reg[CTRL_SPEED] == strapCap_reg[1]
      && basicModeControl_reg[CTRL_DUPLEX] == strapCap_reg[0])
      else $error("forced mode not taken from straps");

   a_adv_strap: assert property (@(posedge clk) disable iff (!resetn)
      sReleaseLoad ##0 strapCap_reg[2] |-> basicModeControl_reg[CTRL_NEG_EN]
      && $countones(advertisedAbility_reg[ABIL_LSB +: 4]) >= 2)
      else $error("advertised set not taken from straps");

   a_straps_held: assert property (@(posedge clk) disable iff (!resetn)
      strapDone_reg ##1 strapDone_reg |-> $stable(strapCap_reg))
      else $error("captured straps changed without reset");

   a_ctrl_write: assert property (@(posedge clk) disable iff (!resetn)
      sCtrlWrite |=> basicModeControl_reg[CTRL_NEG_EN] == $past(writedata[CTRL_NEG_EN])
      && restart_reg == ($past(writedata[CTRL_RESTART])
         || $past(writedata[CTRL_NEG_EN]) != $past(basicModeControl_reg[CTRL_NEG_EN])))
      else $error("control write not applied");

   a_forced_mode: assert property (@(posedge clk) disable iff (!resetn)
      !basicModeControl_reg[CTRL_NEG_EN] [*2]
      |-> speed100 == $past(basicModeControl_reg[CTRL_SPEED])
      && fullDuplex == $past(basicModeControl_reg[CTRL_DUPLEX]) && !negotiationComplete)
      else $error("forced speed or duplex not applied");

   a_best_mode: assert property (@(posedge clk) disable iff (!resetn)
      basicModeControl_reg[CTRL_NEG_EN] && partnerValid && strapDone_reg
      && (partnerAbility & advertisedAbility_reg[ABIL_LSB +: 4] & AB_100FD) != 4'h0
      ##1 basicModeControl_reg[CTRL_NEG_EN] && !restart_reg && !partnerValid
      |=> negotiationComplete && speed100 && fullDuplex)
      else $error("highest common mode not chosen");

   a_bus_answer: assert property (@(posedge clk) disable iff (!resetn)
      (read || write) && waitrequest |=> !waitrequest)
      else $error("bus access not answered in one wait state");

endmodule : phy_strap_config

// >>> board_strap_model.sv
`timescale 1ns/1ps
module board_strap_model #(
   parameter int RESET_HOLD = 12
) (
   input wire logic clk,
   input wire logic resetReq,
   input wire logic [2:0] strapSel,
   output logic resetn = 1'b0,
   output logic negotiationEnableStrap,
   output logic abilitySelectStrapHi,
   output logic abilitySelectStrapLo
);
   int lowCnt = 0;
   // a short request still gives the full low time
   always @(posedge clk) begin
      if (resetReq || (!resetn && lowCnt < RESET_HOLD)) begin
         resetn <= 1'b0;
         lowCnt <= resetn ? 1 : lowCnt + 1;
      end else begin
         resetn <= 1'b1;
         lowCnt <= 0;
      end
   end
   // resistors give a steady level
   assign {negotiationEnableStrap, abilitySelectStrapHi, abilitySelectStrapLo} = strapSel;
endmodule : board_strap_model

// >>> phy_strap_config_tb_top.sv
`timescale 1ns/1ps
module phy_strap_config_tb_top;
   import phy_cfg_pkg::*;
   logic clk = 1'b0, resetReq = 1'b1, read = 1'b0, write = 1'b0, partnerValid = 1'b0;
   logic [2:0] strapSel = 3'h7;
   logic [7:0] address = 8'h00;
   logic [31:0] writedata = 32'h0, readdata, rd;
   logic [3:0] byteenable = 4'hF, partnerAbility = 4'h0;
   logic resetn, en, hi, lo, waitrequest, restartPulse;
   logic negotiationEnabled, negotiationComplete, speed100, fullDuplex;
   logic [15:0] advertisedWord;
   logic [3:0] abilTbl [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'h5, 4'hF};
   int error_cnt = 0, cmp_count = 0;

   board_strap_model #(.RESET_HOLD(RESET_MIN_CYC)) board_strap_model_i (.clk(clk),
      .resetReq(resetReq), .strapSel(strapSel),
      .resetn(resetn), .negotiationEnableStrap(en), .abilitySelectStrapHi(hi),
      .abilitySelectStrapLo(lo));
   phy_strap_config phy_strap_config_i (.clk(clk), .resetn(resetn),
      .negotiationEnableStrap(en), .abilitySelectStrapHi(hi), .abilitySelectStrapLo(lo),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .partnerAbility(partnerAbility), .partnerValid(partnerValid),
      .advertisedWord(advertisedWord), .restartPulse(restartPulse),
      .negotiationEnabled(negotiationEnabled), .negotiationComplete(negotiationComplete),
      .speed100(speed100), .fullDuplex(fullDuplex));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // waits on waitrequest itself, never a fixed count
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= wd;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // one more edge so the accepted write shows on the outputs
      @(posedge clk);
   endtask : bus

   task automatic do_reset(input logic [2:0] s);
      @(posedge clk);
      strapSel <= s;
      resetReq <= 1'b1;
      repeat (12) @(posedge clk);
      resetReq <= 1'b0;
      // the board stretches a short request to the full low time
      do begin
         @(posedge clk);
      end while (resetn !== 1'b1);
      repeat (6) @(posedge clk);
   endtask : do_reset

   task automatic straps_all;
      logic [15:0] w;
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 8'h10, 32'h0);
         chk(advertisedWord, 16'h0001);
         do_reset(i[2:0]);
         w = {7'h0, abilTbl[i], 5'h01};
         chk(advertisedWord, w);
         bus(1'b0, 8'h10, 32'h0);
         chk(rd, {16'h0, w});
         bus(1'b0, 8'h00, 32'h0);
         chk(rd & 32'h3100, i[2] ? 32'h1000 : {18'h0, i[1], 4'h0, i[0], 8'h0});
         chk(negotiationEnabled, i[2]);
         if (!i[2]) chk({speed100, fullDuplex}, i[1:0]);
      end
      $display("test straps_all done");
   endtask : straps_all

   task automatic hold_straps;
      do_reset(3'h7);
      strapSel <= 3'h0;
      repeat (6) @(posedge clk);
      chk({negotiationEnabled, advertisedWord}, 17'h101E1);
      $display("test hold_straps done");
   endtask : hold_straps

   task automatic pulse(input logic [3:0] ab, input logic [2:0] exp);
      @(posedge clk);
      partnerAbility <= ab;
      partnerValid <= 1'b1;
      @(posedge clk);
      partnerValid <= 1'b0;
      repeat (3) @(posedge clk);
      chk({negotiationComplete, speed100, fullDuplex}, exp);
   endtask : pulse

   task automatic negotiate;
      pulse(4'hF, 3'h7);
      pulse(4'h6, 3'h6);
      pulse(4'h3, 3'h5);
      pulse(4'h1, 3'h4);
      bus(1'b1, 8'h10, 32'h00E1);
      pulse(4'hF, 3'h6);
      bus(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h0000_01E1);
      bus(1'b0, 8'h44, 32'h0);
      chk(rd, 32'h0000_000B);
      $display("test negotiate done");
   endtask : negotiate

   task automatic mgmt_override;
      bus(1'b1, 8'h00, 32'h2000);
      chk(restartPulse, 1'b1);
      repeat (3) @(posedge clk);
      chk({negotiationEnabled, speed100, fullDuplex}, 3'h2);
      bus(1'b0, 8'h44, 32'h0);
      chk(rd, 32'h0000_0002);
      bus(1'b1, 8'h00, 32'h0100);
      chk(restartPulse, 1'b0);
      repeat (3) @(posedge clk);
      chk({negotiationEnabled, speed100, fullDuplex}, 3'h1);
      bus(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0);
      $display("test mgmt_override done");
   endtask : mgmt_override

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (25000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge clk);
      resetReq <= 1'b0;
      do begin
         @(posedge clk);
      end while (resetn !== 1'b1);
      repeat (6) @(posedge clk);
      straps_all();
      hold_straps();
      negotiate();
      mgmt_override();
      tally_and_finish();
   end
endmodule : phy_strap_config_tb_top
